// file: hw/dpi_top.sv
// Operation
// - outbound lane takes 8 bits, emits 4-bit groups
// - inbound fifo packs two 4-bit groups per entry, one in two to one mode
// - capture clock writes, system clock reads out; here the capture clock is sampled and the fifo is written on the system clock
// - read bus eight or four times width
// - read valid only with real read data
// - control fifo full flag; controller stops writing
// - command fifo full flag; controller should stop
// - one offset per bank, unused offsets zero
// - single module, presence shown for two slots
// - divided reset synchronised into system clock
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "dpi_cfg.svh"
module dpi_top
  import dpi_pkg::*;
(
  input  wire logic                  SYS_CLK_IN,
  input  wire logic                  RESETN_IN,
  input  wire logic                  DIVIDED_DOMAIN_RESET_IN,
  input  wire logic                  PSEL_IN,
  input  wire logic                  PENABLE_IN,
  input  wire logic                  PWRITE_IN,
  input  wire logic [11:0]           PADDR_IN,
  input  wire logic [31:0]           PWDATA_IN,
  output logic      [31:0]           PRDATA_OUT,
  output logic                       PREADY_OUT,
  output logic                       PSLVERR_OUT,
  input  wire logic                  COMMAND_WRITE_ENABLE_IN,
  input  wire logic [`DPI_CMD_W-1:0] COMMAND_IN,
  output logic                       COMMAND_FIFO_FULL_OUT,
  input  wire logic                  CONTROL_WORD_WRITE_ENABLE_IN,
  input  wire logic [`DPI_CTL_W-1:0] CONTROL_WORD_IN,
  output logic                       CONTROL_FIFO_FULL_OUT,
  input  wire logic                  WRITE_DATA_ENABLE_IN,
  input  wire logic [63:0]           WRITE_DATA_BUS_IN,
  input  wire logic [7:0]            WRITE_MASK_BUS_IN,
  output logic                       WRITE_FIFO_FULL_OUT,
  output logic [`DPI_CMD_W-1:0]      MEM_COMMAND_OUT,
  output logic                       MEM_COMMAND_VALID_OUT,
  output logic [`DPI_CTL_W-1:0]      PHY_CONTROL_WORD_OUT,
  output logic                       PHY_CONTROL_VALID_OUT,
  output logic [31:0]                SER_GROUP_DATA_OUT,
  output logic [3:0]                 SER_GROUP_MASK_OUT,
  output logic                       SER_GROUP_VALID_OUT,
  input  wire logic                  HALF_RATE_CAPTURE_CLOCK_IN,
  input  wire logic [31:0]           DESER_GROUP_IN,
  output logic [`DPI_RD_W-1:0]       READ_DATA_OUT,
  output logic                       READ_DATA_VALID_OUT,
  output logic [5:0]                 CALIB_RD_OFFSET_0_OUT,
  output logic [5:0]                 CALIB_RD_OFFSET_1_OUT,
  output logic [5:0]                 CALIB_RD_OFFSET_2_OUT,
  output logic                       CALIB_COMPLETE_OUT,
  input  wire logic                  SLOT_0_PRESENT_IN,
  input  wire logic                  SLOT_1_PRESENT_IN,
  output logic                       SLOT_0_PRESENT_OUT,
  output logic                       SLOT_1_PRESENT_OUT
);
  // ******************************************************************
  // declarations
  // ******************************************************************
  logic                  div_rst_s1_r;
  logic                  div_rst_s2_r;
  logic                  rst_n;
  logic                  run_r;
  logic                  calib_r;
  logic                  ratio4_r;
  logic [1:0]            banks_r;
  dpi_offset_t           offs_r [0:2];
  dpi_offset_t           off_out_r [0:2];
  logic                  rd_ovf_r;
  logic                  bad_cmd_r;
  logic [31:0]           prdata_r;
  logic                  apb_wr;
  logic                  apb_hit;
  logic [31:0]           ctrl_rd;
  logic [31:0]           stat_rd;
  logic                  cmd_push;
  logic                  cmd_empty;
  logic                  cmd_pop;
  logic [`DPI_CMD_W-1:0] cmd_head;
  logic                  ctl_push;
  logic                  ctl_empty;
  logic                  ctl_pop;
  logic [`DPI_CTL_W-1:0] ctl_head;
  logic                  wr_empty;
  logic                  wr_pop;
  logic [`DPI_WR_W-1:0]  wr_head;
  logic [`DPI_WR_W-1:0]  wr_hold_r;
  dpi_ser_state_t        ser_state_r;
  dpi_ser_state_t        ser_state_nxt;
  logic [31:0]           lo_grp;
  logic [31:0]           hi_grp;
  logic [31:0]           ser_data_r;
  logic [3:0]            ser_mask_r;
  logic                  ser_valid_r;
  logic                  cap_s1_r;
  logic                  cap_s2_r;
  logic                  cap_s3_r;
  logic [31:0]           grp_s1_r;
  logic [31:0]           grp_s2_r;
  logic                  cap_edge;
  logic                  half_r;
  logic [31:0]           first_r;
  logic [`DPI_RD_W-1:0]  pack_w;
  logic                  rd_push;
  logic                  rd_full;
  logic                  rd_empty;
  logic                  rd_pop;
  logic [`DPI_RD_W-1:0]  rd_head;
  logic [`DPI_RD_W-1:0]  rd_data_r;
  logic                  rd_valid_r;
  logic                  slot0_s1_r;
  logic                  slot0_s2_r;
  logic                  slot1_s1_r;
  logic                  slot1_s2_r;

  // ******************************************************************
  // reset
  // ******************************************************************
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RESETN_IN) begin
      div_rst_s1_r <= 1'h1;
      div_rst_s2_r <= 1'h1;
    end else begin
      div_rst_s1_r <= DIVIDED_DOMAIN_RESET_IN;
      div_rst_s2_r <= div_rst_s1_r;
    end
  end
  assign rst_n = RESETN_IN & ~div_rst_s2_r;

  default clocking dpi_cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!rst_n);

  rst_sync_a: assert property (disable iff (!RESETN_IN)
    DIVIDED_DOMAIN_RESET_IN |-> ##2 !rst_n)
    else $error("divided reset did not reach the logic");

  // ******************************************************************
  // register bus
  // ******************************************************************
  assign apb_hit = (PADDR_IN == `DPI_CTRL_OFF) ||
                   (PADDR_IN == `DPI_OFFS_OFF) ||
                   (PADDR_IN == `DPI_STAT_OFF);
  assign apb_wr      = PSEL_IN & PENABLE_IN & PWRITE_IN & apb_hit;
  assign PREADY_OUT  = 1'h1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~apb_hit;
  assign PRDATA_OUT  = prdata_r;

  assign ctrl_rd = {26'h000_0000, banks_r, 1'h0, ratio4_r, calib_r, run_r};
  assign stat_rd = {22'h00_0000, bad_cmd_r, rd_ovf_r, 1'h0,
                    slot0_s2_r & slot1_s2_r, slot1_s2_r, slot0_s2_r,
                    rd_empty, WRITE_FIFO_FULL_OUT, CONTROL_FIFO_FULL_OUT,
                    COMMAND_FIFO_FULL_OUT};

  // read data is latched in the setup phase so no wait state is needed
  always_ff @(posedge SYS_CLK_IN) begin
    if (!rst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) begin
      case (PADDR_IN)
        `DPI_CTRL_OFF: prdata_r <= ctrl_rd;
        `DPI_OFFS_OFF: prdata_r <= {10'h000, offs_r[2], 2'h0, offs_r[1],
                                    2'h0, offs_r[0]};
        `DPI_STAT_OFF: prdata_r <= stat_rd;
        default:       prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!rst_n) begin
      run_r    <= 1'h0;
      calib_r  <= 1'h0;
      ratio4_r <= `DPI_RATIO_RST;
      banks_r  <= `DPI_BANKS_RST;
    end else if (apb_wr && PADDR_IN == `DPI_CTRL_OFF) begin
      run_r    <= PWDATA_IN[`DPI_RUN_BIT];
      calib_r  <= PWDATA_IN[`DPI_CALIB_BIT];
      ratio4_r <= PWDATA_IN[`DPI_RATIO_BIT];
      banks_r  <= PWDATA_IN[`DPI_BANKS_LSB +: 2];
    end
  end
  assign CALIB_COMPLETE_OUT = calib_r;

  // a new event in the clearing cycle keeps its flag set
  always_ff @(posedge SYS_CLK_IN) begin
    if (!rst_n) begin
      rd_ovf_r  <= 1'h0;
      bad_cmd_r <= 1'h0;
    end else begin
      rd_ovf_r  <= (rd_push & rd_full) | (rd_ovf_r & ~(apb_wr &&
                   PADDR_IN == `DPI_STAT_OFF && PWDATA_IN[`DPI_OVF_BIT]));
      bad_cmd_r <= (cmd_push &&
                    COMMAND_IN[2:0] != `DPI_CMD_NODATA &&
                    COMMAND_IN[2:0] != `DPI_CMD_WRITE &&
                    COMMAND_IN[2:0] != `DPI_CMD_READ) |
                   (bad_cmd_r & ~(apb_wr && PADDR_IN == `DPI_STAT_OFF &&
                    PWDATA_IN[`DPI_BADCMD_BIT]));
    end
  end

  // ******************************************************************
  // read offsets per bank
  // ******************************************************************
  for (genvar k = 0; k < 3; k++) begin : g_off
    always_ff @(posedge SYS_CLK_IN) begin
      if (!rst_n) begin
        offs_r[k]    <= 6'h00;
        off_out_r[k] <= 6'h00;
      end else begin
        if (apb_wr && PADDR_IN == `DPI_OFFS_OFF) begin
          offs_r[k] <= PWDATA_IN[k*`DPI_OFFS_STRIDE +: 6];
        end
        off_out_r[k] <= (k < banks_r) ? offs_r[k] : 6'h00;
      end
    end
  end
  assign CALIB_RD_OFFSET_0_OUT = off_out_r[0];
  assign CALIB_RD_OFFSET_1_OUT = off_out_r[1];
  assign CALIB_RD_OFFSET_2_OUT = off_out_r[2];

  off_unused_a: assert property (
    banks_r == 2'h1 ##1 banks_r == 2'h1 |->
    CALIB_RD_OFFSET_1_OUT == 6'h00 && CALIB_RD_OFFSET_2_OUT == 6'h00)
    else $error("unused bank offset not zero");

  // ******************************************************************
  // command and control word fifos
  // ******************************************************************
  assign cmd_push = COMMAND_WRITE_ENABLE_IN & ~COMMAND_FIFO_FULL_OUT;
  assign ctl_push = CONTROL_WORD_WRITE_ENABLE_IN & ~CONTROL_FIFO_FULL_OUT;
  // holding the drains until software sets run lets the fifos fill
  assign cmd_pop  = run_r & ~cmd_empty;
  assign ctl_pop  = run_r & ~ctl_empty;

  dpi_fifo #(.W(`DPI_CMD_W)) u_cmd_fifo (
    .clk_in      (SYS_CLK_IN),
    .rst_n_in    (rst_n),
    .wr_en_in    (COMMAND_WRITE_ENABLE_IN),
    .wr_data_in  (COMMAND_IN),
    .rd_en_in    (cmd_pop),
    .rd_data_out (cmd_head),
    .full_out    (COMMAND_FIFO_FULL_OUT),
    .empty_out   (cmd_empty)
  );

  dpi_fifo #(.W(`DPI_CTL_W)) u_ctl_fifo (
    .clk_in      (SYS_CLK_IN),
    .rst_n_in    (rst_n),
    .wr_en_in    (CONTROL_WORD_WRITE_ENABLE_IN),
    .wr_data_in  (CONTROL_WORD_IN),
    .rd_en_in    (ctl_pop),
    .rd_data_out (ctl_head),
    .full_out    (CONTROL_FIFO_FULL_OUT),
    .empty_out   (ctl_empty)
  );

  always_ff @(posedge SYS_CLK_IN) begin
    if (!rst_n) begin
      MEM_COMMAND_OUT       <= '0;
      MEM_COMMAND_VALID_OUT <= 1'h0;
      PHY_CONTROL_WORD_OUT  <= 32'h0000_0000;
      PHY_CONTROL_VALID_OUT <= 1'h0;
    end else begin
      MEM_COMMAND_VALID_OUT <= cmd_pop;
      PHY_CONTROL_VALID_OUT <= ctl_pop;
      if (cmd_pop) begin
        MEM_COMMAND_OUT <= cmd_head;
      end
      if (ctl_pop) begin
        PHY_CONTROL_WORD_OUT <= ctl_head;
      end
    end
  end

  ctl_full_a: assert property (
    CONTROL_FIFO_FULL_OUT && !ctl_pop |=> CONTROL_FIFO_FULL_OUT)
    else $error("control fifo accepted a word while full");

  cmd_full_a: assert property (
    COMMAND_FIFO_FULL_OUT && !cmd_pop ##1 !cmd_pop |->
    COMMAND_FIFO_FULL_OUT && !cmd_push)
    else $error("command fifo accepted a command while full");

  // ******************************************************************
  // outbound write data serializer
  // ******************************************************************
  dpi_fifo #(.W(`DPI_WR_W)) u_wr_fifo (
    .clk_in      (SYS_CLK_IN),
    .rst_n_in    (rst_n),
    .wr_en_in    (WRITE_DATA_ENABLE_IN),
    .wr_data_in  ({WRITE_MASK_BUS_IN, WRITE_DATA_BUS_IN}),
    .rd_en_in    (wr_pop),
    .rd_data_out (wr_head),
    .full_out    (WRITE_FIFO_FULL_OUT),
    .empty_out   (wr_empty)
  );

  always_comb begin
    ser_state_nxt = ser_state_r;
    case (ser_state_r)
      OS_IDLE:  ser_state_nxt = (run_r & ~wr_empty) ? OS_LOW : OS_IDLE;
      OS_LOW:   ser_state_nxt = OS_HIGH;
      OS_HIGH:  ser_state_nxt = (run_r & ~wr_empty) ? OS_LOW : OS_IDLE;
      default:  ser_state_nxt = OS_IDLE;
    endcase
  end
  assign wr_pop = (ser_state_nxt == OS_LOW);

  for (genvar i = 0; i < `DPI_LANES; i++) begin : g_lane
    assign lo_grp[4*i +: 4] = wr_head[8*i +: 4];
    assign hi_grp[4*i +: 4] = wr_hold_r[8*i+4 +: 4];
    assign pack_w[8*i +: 8] = ratio4_r ?
      {grp_s2_r[4*i +: 4], first_r[4*i +: 4]} :
      {4'h0, grp_s2_r[4*i +: 4]};
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!rst_n) begin
      ser_state_r <= OS_IDLE;
      wr_hold_r   <= '0;
      ser_data_r  <= 32'h0000_0000;
      ser_mask_r  <= 4'h0;
      ser_valid_r <= 1'h0;
    end else begin
      ser_state_r <= ser_state_nxt;
      ser_valid_r <= (ser_state_nxt != OS_IDLE);
      if (wr_pop) begin
        wr_hold_r  <= wr_head;
        ser_data_r <= lo_grp;
        ser_mask_r <= wr_head[67:64];
      end else if (ser_state_nxt == OS_HIGH) begin
        ser_data_r <= hi_grp;
        ser_mask_r <= wr_hold_r[71:68];
      end
    end
  end
  assign SER_GROUP_DATA_OUT  = ser_data_r;
  assign SER_GROUP_MASK_OUT  = ser_mask_r;
  assign SER_GROUP_VALID_OUT = ser_valid_r;

  sequence wr_take_s;
    wr_pop;
  endsequence
  sequence two_groups_s;
    SER_GROUP_VALID_OUT [*2];
  endsequence
  ser_pair_a: assert property (
    wr_take_s |=> two_groups_s ##0 SER_GROUP_DATA_OUT == hi_grp)
    else $error("entry not sent as two groups");

  // ******************************************************************
  // inbound read capture
  // ******************************************************************
  // the capture clock is sampled like a pin; groups must be held for
  // several system cycles, which limits the usable capture rate
  always_ff @(posedge SYS_CLK_IN) begin
    if (!rst_n) begin
      cap_s1_r <= 1'h0;
      cap_s2_r <= 1'h0;
      cap_s3_r <= 1'h0;
      grp_s1_r <= 32'h0000_0000;
      grp_s2_r <= 32'h0000_0000;
    end else begin
      cap_s1_r <= HALF_RATE_CAPTURE_CLOCK_IN;
      cap_s2_r <= cap_s1_r;
      cap_s3_r <= cap_s2_r;
      grp_s1_r <= DESER_GROUP_IN;
      grp_s2_r <= grp_s1_r;
    end
  end
  assign cap_edge = cap_s2_r & ~cap_s3_r;
  assign rd_push  = cap_edge & (~ratio4_r | half_r);

  always_ff @(posedge SYS_CLK_IN) begin
    if (!rst_n) begin
      half_r  <= 1'h0;
      first_r <= 32'h0000_0000;
    end else if (cap_edge & ratio4_r) begin
      half_r <= ~half_r;
      if (!half_r) begin
        first_r <= grp_s2_r;
      end
    end
  end

  dpi_fifo #(.W(`DPI_RD_W)) u_rd_fifo (
    .clk_in      (SYS_CLK_IN),
    .rst_n_in    (rst_n),
    .wr_en_in    (rd_push),
    .wr_data_in  (pack_w),
    .rd_en_in    (rd_pop),
    .rd_data_out (rd_head),
    .full_out    (rd_full),
    .empty_out   (rd_empty)
  );
  assign rd_pop = ~rd_empty;

  always_ff @(posedge SYS_CLK_IN) begin
    if (!rst_n) begin
      rd_data_r  <= '0;
      rd_valid_r <= 1'h0;
    end else begin
      rd_valid_r <= rd_pop;
      if (rd_pop) begin
        rd_data_r <= rd_head;
      end
    end
  end
  assign READ_DATA_OUT       = rd_data_r;
  assign READ_DATA_VALID_OUT = rd_valid_r;

  rd_valid_a: assert property (
    READ_DATA_VALID_OUT |-> $past(!rd_empty) &&
    READ_DATA_OUT == $past(rd_head))
    else $error("read valid without stored data");

  pack_a: assert property (
    cap_edge && ratio4_r && !half_r |-> !rd_push ##1 half_r)
    else $error("group stored without its pair");

  width_a: assert property (
    $past(!ratio4_r) && READ_DATA_VALID_OUT && $past(rd_push, 2) |->
    (READ_DATA_OUT & 64'hF0F0_F0F0_F0F0_F0F0) == 64'h0000_0000_0000_0000)
    else $error("upper nibbles set in two to one mode");

  // ******************************************************************
  // module presence
  // ******************************************************************
  always_ff @(posedge SYS_CLK_IN) begin
    if (!rst_n) begin
      slot0_s1_r <= 1'h0;
      slot0_s2_r <= 1'h0;
      slot1_s1_r <= 1'h0;
      slot1_s2_r <= 1'h0;
    end else begin
      slot0_s1_r <= SLOT_0_PRESENT_IN;
      slot0_s2_r <= slot0_s1_r;
      slot1_s1_r <= SLOT_1_PRESENT_IN;
      slot1_s2_r <= slot1_s1_r;
    end
  end
  assign SLOT_0_PRESENT_OUT = slot0_s2_r;
  assign SLOT_1_PRESENT_OUT = slot1_s2_r;

  slot_sync_a: assert property (
    SLOT_0_PRESENT_IN ##1 SLOT_0_PRESENT_IN |=> SLOT_0_PRESENT_OUT)
    else $error("slot presence not passed through");
endmodule : dpi_top

// file: hw/dpi_cfg.svh
`ifndef DPI_CFG_SVH
`define DPI_CFG_SVH

// ********************************************************************
// sizes
// ********************************************************************
`define DPI_LANES         8
`define DPI_FIFO_ENTRIES  4
`define DPI_FIFO_FULL_CNT 3'h4
`define DPI_CMD_W         19
`define DPI_CTL_W         32
`define DPI_WR_W          72
`define DPI_RD_W          64

// ********************************************************************
// register offsets
// ********************************************************************
`define DPI_CTRL_OFF      12'h000
`define DPI_OFFS_OFF      12'h004
`define DPI_STAT_OFF      12'h008

// ********************************************************************
// control fields and reset values
// ********************************************************************
`define DPI_RUN_BIT       0
`define DPI_CALIB_BIT     1
`define DPI_RATIO_BIT     2
`define DPI_BANKS_LSB     4
`define DPI_OFFS_STRIDE   8
`define DPI_RATIO_RST     1'h1
`define DPI_BANKS_RST     2'h1
`define DPI_OVF_BIT       8
`define DPI_BADCMD_BIT    9

// ********************************************************************
// command type codes
// ********************************************************************
`define DPI_CMD_NODATA    3'h4
`define DPI_CMD_WRITE     3'h1
`define DPI_CMD_READ      3'h3

`endif

// file: hw/dpi_pkg.sv
package dpi_pkg;
  typedef enum logic [1:0] {OS_IDLE, OS_LOW, OS_HIGH} dpi_ser_state_t;
  typedef logic [5:0] dpi_offset_t;
endpackage : dpi_pkg

// file: hw/dpi_fifo.sv
`timescale 1ns/1ps
`include "dpi_cfg.svh"
module dpi_fifo #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         wr_en_in,
  input  wire logic [W-1:0] wr_data_in,
  input  wire logic         rd_en_in,
  output logic      [W-1:0] rd_data_out,
  output logic              full_out,
  output logic              empty_out
);
  logic [W-1:0] mem_r [0:`DPI_FIFO_ENTRIES-1];
  logic [1:0]   wr_ptr_r;
  logic [1:0]   rd_ptr_r;
  logic [2:0]   count_r;
  logic         push;
  logic         pop;

  // requests against a full or empty store are dropped, never wrap
  assign push        = wr_en_in & ~full_out;
  assign pop         = rd_en_in & ~empty_out;
  assign full_out    = (count_r == `DPI_FIFO_FULL_CNT);
  assign empty_out   = (count_r == 3'h0);
  assign rd_data_out = mem_r[rd_ptr_r];

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wr_ptr_r <= 2'h0;
      rd_ptr_r <= 2'h0;
      count_r  <= 3'h0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 2'h1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 2'h1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 3'h1;
      end else if (pop & ~push) begin
        count_r <= count_r - 3'h1;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    full_out && !pop |=> count_r == `DPI_FIFO_FULL_CNT)
    else $error("fifo count moved past full");
endmodule : dpi_fifo

// file: verification/dpi_mem_model.sv
`timescale 1ns/1ps
module dpi_mem_model (
  input  wire logic        clk_in,
  output logic             cap_clk_out,
  output logic [31:0]      group_out
);
  // ******************************************************************
  // memory side capture source
  // ******************************************************************
  initial begin
    cap_clk_out = 1'b0;
    group_out   = 32'h0000_0000;
  end
  // capture clock stands still between groups; idle data is inverted
  task automatic send_group(input logic [31:0] g);
    @(posedge clk_in) group_out <= g;
    repeat (4) @(posedge clk_in);
    cap_clk_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    cap_clk_out <= 1'b0;
    group_out   <= ~g;
    repeat (2) @(posedge clk_in);
  endtask : send_group
endmodule : dpi_mem_model

// file: verification/testbench.sv
`timescale 1ns/1ps
`include "dpi_cfg.svh"
module testbench;
  // ******************************************************************
  // stimulus, expectations and result watch
  // ******************************************************************
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0;
  logic        pwr = 1'b0, s0 = 1'b0, s1 = 1'b0, cwe = 1'b0;
  logic        kwe = 1'b0, wde = 1'b0, err, cap, cf, kf, wf, pr;
  logic        mcv, kv, sgv, rdv, cal, so0, so1, pe, drst = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [18:0] cmd = '0, mc;
  logic [31:0] pwd = '0, ctl = '0, rd, grp, prd, kw, sg;
  logic [63:0] wd = '0, rdat;
  logic [7:0]  wm = 8'h00;
  logic [5:0]  o0, o1, o2;
  logic [3:0]  sm;
  logic [18:0] cq[$];
  logic [31:0] kq[$];
  logic [35:0] wq[$];
  logic [63:0] rq[$];
  int          n_errors = 0, tests_run = 0;
  integer      seed = 32'hf05534f5;

  always #50 clk = ~clk;

  dpi_top uut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n),
    .DIVIDED_DOMAIN_RESET_IN(drst), .PSEL_IN(psel), .PENABLE_IN(pen),
    .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
    .PREADY_OUT(pr), .PSLVERR_OUT(pe), .COMMAND_WRITE_ENABLE_IN(cwe),
    .COMMAND_IN(cmd), .COMMAND_FIFO_FULL_OUT(cf),
    .CONTROL_WORD_WRITE_ENABLE_IN(kwe), .CONTROL_WORD_IN(ctl),
    .CONTROL_FIFO_FULL_OUT(kf), .WRITE_DATA_ENABLE_IN(wde),
    .WRITE_DATA_BUS_IN(wd), .WRITE_MASK_BUS_IN(wm),
    .WRITE_FIFO_FULL_OUT(wf), .MEM_COMMAND_OUT(mc),
    .MEM_COMMAND_VALID_OUT(mcv), .PHY_CONTROL_WORD_OUT(kw),
    .PHY_CONTROL_VALID_OUT(kv), .SER_GROUP_DATA_OUT(sg),
    .SER_GROUP_MASK_OUT(sm), .SER_GROUP_VALID_OUT(sgv),
    .HALF_RATE_CAPTURE_CLOCK_IN(cap), .DESER_GROUP_IN(grp),
    .READ_DATA_OUT(rdat), .READ_DATA_VALID_OUT(rdv),
    .CALIB_RD_OFFSET_0_OUT(o0), .CALIB_RD_OFFSET_1_OUT(o1),
    .CALIB_RD_OFFSET_2_OUT(o2), .CALIB_COMPLETE_OUT(cal),
    .SLOT_0_PRESENT_IN(s0), .SLOT_1_PRESENT_IN(s1),
    .SLOT_0_PRESENT_OUT(so0), .SLOT_1_PRESENT_OUT(so1));

  dpi_mem_model mem (.clk_in(clk), .cap_clk_out(cap), .group_out(grp));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("counts: %0d mismatches, %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pwd  <= d;
    @(posedge clk) pen <= 1'b1;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pr !== 1'b1);
    r = prd;
    err = pe;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  function automatic logic [63:0] pack(input logic [31:0] a, b);
    for (int i = 0; i < 8; i++) pack[8*i +: 8] = {b[4*i +: 4], a[4*i +: 4]};
  endfunction : pack

  function automatic logic [31:0] half(input logic [63:0] d, input int h);
    for (int i = 0; i < 8; i++) half[4*i +: 4] = d[8*i+4*h +: 4];
  endfunction : half

  always @(posedge clk) begin
    if (mcv === 1'b1) check(mc, cq.pop_front());
    if (kv === 1'b1) check(kw, kq.pop_front());
    if (sgv === 1'b1) check({sm, sg}, wq.pop_front());
    if (rdv === 1'b1) check(rdat, rq.pop_front());
  end

  initial begin
    #(3000 * 100);
    n_errors++;
    complete_run();
  end

  initial begin
    logic [2:0]  codes [3];
    logic [18:0] c;
    logic [63:0] d;
    logic [31:0] g1, g2;
    codes = '{`DPI_CMD_NODATA, `DPI_CMD_WRITE, `DPI_CMD_READ};
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, `DPI_CTRL_OFF, '0, rd);
    check(rd, 32'h0000_0014);
    apb(1'b0, 12'hffc, '0, rd);
    check({rd, err}, 33'h0_0000_0001);
    rd = $random(seed);
    {s1, s0} <= rd[1:0];
    repeat (3) @(posedge clk);
    check({so1, so0}, rd[1:0]);
    apb(1'b1, `DPI_OFFS_OFF, 32'h002a_150b, rd);
    for (int b = 1; b < 4; b++) begin
      apb(1'b1, `DPI_CTRL_OFF, 32'h0000_0006 | (b << 4), rd);
      repeat (2) @(posedge clk);
      check({o2, o1, o0}, {(b > 2) ? 6'h2a : 6'h00,
                           (b > 1) ? 6'h15 : 6'h00, 6'h0b});
    end
    check(cal, 1'b1);
    $display("test registers done");
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      rd = $random(seed);
      c = {rd[15:0], codes[k % 3]};
      cwe <= 1'b1;
      // the fifth control word would meet a full flag, so it is withheld
      kwe <= (k < 4);
      cmd <= c;
      ctl <= ~rd;
      if (k < 4) cq.push_back(c);
      if (k < 4) kq.push_back(~rd);
    end
    @(posedge clk);
    cwe <= 1'b0;
    kwe <= 1'b0;
    #1 check({cf, kf}, 2'h3);
    apb(1'b1, `DPI_CTRL_OFF, 32'h0000_0017, rd);
    repeat (10) @(posedge clk);
    check({cf, kf, 16'(cq.size()), 16'(kq.size())}, '0);
    $display("test command fifos done");
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      d = {$random(seed), $random(seed)};
      wde <= 1'b1;
      wd  <= d;
      wm  <= d[7:0] ^ 8'h5a;
      wq.push_back({d[3:0] ^ 4'ha, half(d, 0)});
      wq.push_back({d[7:4] ^ 4'h5, half(d, 1)});
    end
    @(posedge clk) wde <= 1'b0;
    repeat (10) @(posedge clk);
    check(wq.size(), 0);
    $display("test write stream done");
    g1 = $random(seed);
    g2 = $random(seed);
    rq.push_back(pack(g1, g2));
    mem.send_group(g1);
    mem.send_group(g2);
    apb(1'b1, `DPI_CTRL_OFF, 32'h0000_0013, rd);
    rq.push_back(pack(g1 ^ g2, 32'h0000_0000));
    mem.send_group(g1 ^ g2);
    repeat (10) @(posedge clk);
    check(rq.size(), 0);
    $display("test read path done");
    drst <= 1'b1;
    repeat (4) @(posedge clk);
    drst <= 1'b0;
    repeat (3) @(posedge clk);
    apb(1'b0, `DPI_CTRL_OFF, '0, rd);
    check(rd, 32'h0000_0014);
    $display("test divided reset done");
    complete_run();
  end
endmodule : testbench
